// file: logic/akfr_top.sv
// Purpose: Checks incoming keep-alive headers and sends the 64-byte answer.
// Assumes: Byte stream from the MAC, one header per frame, start marked by sof.
// Notes: Stream destination and enable are exported for the packetiser.
// How it works
// - Header starts with 0xA1EC, high byte first.
// - Byte 0x02 carries version 0x03.
// - Keep-alive command code 0xFE at 0x03.
// - Length and payload checksum are zero.
// - Header checksum at 0x3E covers 0x02..0x3D.
// - CRC-CCITT, poly 0x1021, start zero, checked.
// - Valid command gets same-layout answer with status.
// - Answer byte 0x04 names the flash target.
// - Flags field carries no meaning here.
// - Stream data per packet at most 1400 bytes.
// - Fields are unsigned 8, 16, 32 bits.
// - Streaming enabled out of reset.
// - Default destination 224.0.0.1 port 10002.
// - Destination changeable through interface configuration.
// - Packet is 32-byte header plus data, 1432 max.
`timescale 1ns/1ps
module akfr_top
    import akfr_pkg::*;
#(
    parameter int DATA_MAX = AKFR_STREAM_DATA_MAX,
    parameter int HDR_BYTES = AKFR_STREAM_HDR_BYTES
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic rx_valid_i,
    input wire logic rx_sof_i,
    input wire logic [7:0] rx_data_i,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic [7:0] tx_data_o,
    output logic tx_last_o,
    input wire logic [7:0] flash_target_i,
    input wire logic [7:0] result_code_i,
    input wire logic cfg_we_i,
    input wire logic [31:0] cfg_group_i,
    input wire logic [15:0] cfg_port_i,
    input wire logic cfg_enable_i,
    input wire logic [10:0] stream_len_i,
    output logic stream_en_o,
    output logic [31:0] stream_group_o,
    output logic [15:0] stream_port_o,
    output logic [10:0] stream_pkt_len_o,
    output logic cmd_ok_o,
    output logic cmd_drop_o
);
    typedef struct packed {
        akfr_rx_state_t st;
        logic [5:0] rx_ofs;
        logic [15:0] rx_crc;
        logic [15:0] rx_ck;
        logic hdr_bad;
        logic is_alive;
        logic [5:0] tx_ofs;
        logic [15:0] tx_crc;
        logic [7:0] target;
        logic [7:0] status;
        logic en;
        logic [31:0] group;
        logic [15:0] port;
        logic [10:0] pkt_len;
        logic ok;
        logic drop;
        logic [5:0] out_ofs;
        logic [15:0] out_crc;
    } akfr_top_st_t;

    akfr_top_st_t s_r;
    akfr_top_st_t s_nxt;
    logic [7:0] tx_byte;
    logic fifo_in_ready;
    logic fifo_push;
    logic fifo_out_valid;
    logic [8:0] fifo_out;

    // All checks share this clock and stay quiet while reset is held.
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // ==========================================================
    // Answer byte generator.
    // Bytes not named here are sent as zero, including flags and the aux bytes.
    always_comb begin
        tx_byte = 8'h00;
        if (s_r.tx_ofs == AKFR_OFS_PRE_HI) begin
            tx_byte = AKFR_PREAMBLE[15:8];
        end else if (s_r.tx_ofs == AKFR_OFS_PRE_LO) begin
            tx_byte = AKFR_PREAMBLE[7:0];
        end else if (s_r.tx_ofs == AKFR_OFS_REV) begin
            tx_byte = AKFR_PROTO_REV;
        end else if (s_r.tx_ofs == AKFR_OFS_CMD) begin
            tx_byte = AKFR_CMD_ALIVE;
        end else if (s_r.tx_ofs == AKFR_OFS_TARGET) begin
            tx_byte = s_r.target;
        end else if (s_r.tx_ofs == AKFR_OFS_STATUS) begin
            tx_byte = s_r.status;
        end else if (s_r.tx_ofs == AKFR_OFS_HCK_HI) begin
            tx_byte = s_r.tx_crc[15:8];
        end else if (s_r.tx_ofs == AKFR_OFS_LAST) begin
            tx_byte = s_r.tx_crc[7:0];
        end
    end

    assign fifo_push = (s_r.st == AKFR_RX_SEND);

    // ==========================================================
    // Main state update.
    always_comb begin
        logic [7:0] b;
        logic [15:0] c_next;
        b = rx_data_i;
        c_next = akfr_crc_byte(s_r.rx_crc, b);
        s_nxt = s_r;
        s_nxt.ok = 1'b0;
        s_nxt.drop = 1'b0;
        // Configuration port rewrites the stream destination at any time.
        if (cfg_we_i) begin
            s_nxt.group = cfg_group_i;
            s_nxt.port = cfg_port_i;
            s_nxt.en = cfg_enable_i;
        end
        // Clamp the data section so a packet never passes the size limit.
        if (stream_len_i > 11'(DATA_MAX)) begin
            s_nxt.pkt_len = 11'(DATA_MAX + HDR_BYTES);
        end else begin
            s_nxt.pkt_len = stream_len_i + 11'(HDR_BYTES);
        end
        // Count bytes as the sink takes them and run a second checksum over them.
        // The port checks use this, so a FIFO fault cannot hide behind
        // a byte generator that is right.
        if (tx_valid_o && tx_ready_i) begin
            s_nxt.out_ofs = s_r.out_ofs + 6'h01;
            if (s_r.out_ofs == AKFR_OFS_PRE_HI) begin
                s_nxt.out_crc = AKFR_CRC_INIT;
            end else if (s_r.out_ofs >= AKFR_OFS_REV && s_r.out_ofs <= AKFR_OFS_PCK_END) begin
                s_nxt.out_crc = akfr_crc_byte(s_r.out_crc, tx_data_o);
            end
        end
        case (s_r.st)
            AKFR_RX_HDR: begin
                if (rx_valid_i) begin
                    if (rx_sof_i) begin
                        s_nxt.rx_ofs = 6'h01;
                        s_nxt.rx_crc = AKFR_CRC_INIT;
                        s_nxt.hdr_bad = (b != AKFR_PREAMBLE[15:8]);
                        s_nxt.is_alive = 1'b0;
                    end else begin
                        s_nxt.rx_ofs = s_r.rx_ofs + 6'h01;
                        if (s_r.rx_ofs == AKFR_OFS_PRE_LO && b != AKFR_PREAMBLE[7:0]) begin
                            s_nxt.hdr_bad = 1'b1;
                        end
                        if (s_r.rx_ofs == AKFR_OFS_REV && b != AKFR_PROTO_REV) begin
                            s_nxt.hdr_bad = 1'b1;
                        end
                        if (s_r.rx_ofs == AKFR_OFS_CMD) begin
                            s_nxt.is_alive = (b == AKFR_CMD_ALIVE);
                        end
                        if (s_r.rx_ofs >= AKFR_OFS_LEN && s_r.rx_ofs <= AKFR_OFS_LEN_END
                            && b != 8'h00) begin
                            s_nxt.hdr_bad = 1'b1;
                        end
                        if (s_r.rx_ofs >= AKFR_OFS_PCK && s_r.rx_ofs <= AKFR_OFS_PCK_END
                            && b != 8'h00) begin
                            s_nxt.hdr_bad = 1'b1;
                        end
                        // Bytes 0x02..0x3D feed the checksum; flags are never decoded.
                        if (s_r.rx_ofs >= AKFR_OFS_REV && s_r.rx_ofs <= AKFR_OFS_PCK_END) begin
                            s_nxt.rx_crc = c_next;
                        end
                        if (s_r.rx_ofs == AKFR_OFS_HCK_HI) begin
                            s_nxt.rx_ck[15:8] = b;
                        end
                        if (s_r.rx_ofs == AKFR_OFS_LAST) begin
                            s_nxt.rx_ofs = '0;
                            // The answer is decided only once the whole header is in.
                            if (!s_r.hdr_bad && s_r.is_alive
                                && {s_r.rx_ck[15:8], b} == s_r.rx_crc) begin
                                s_nxt.st = AKFR_RX_WAIT;
                                s_nxt.ok = 1'b1;
                                s_nxt.target = flash_target_i;
                                s_nxt.status = result_code_i;
                            end else begin
                                s_nxt.drop = 1'b1;
                            end
                        end
                    end
                end
            end
            AKFR_RX_WAIT: begin
                // One cycle to seed the transmit checksum before bytes leave.
                s_nxt.tx_ofs = '0;
                s_nxt.tx_crc = AKFR_CRC_INIT;
                s_nxt.st = AKFR_RX_SEND;
            end
            AKFR_RX_SEND: begin
                if (fifo_in_ready) begin
                    if (s_r.tx_ofs >= AKFR_OFS_REV && s_r.tx_ofs <= AKFR_OFS_PCK_END) begin
                        s_nxt.tx_crc = akfr_crc_byte(s_r.tx_crc, tx_byte);
                    end
                    s_nxt.tx_ofs = s_r.tx_ofs + 6'h01;
                    if (s_r.tx_ofs == AKFR_OFS_LAST) begin
                        s_nxt.st = AKFR_RX_HDR;
                    end
                end
            end
            default: begin
                s_nxt.st = AKFR_RX_HDR;
            end
        endcase
    end

    // ==========================================================
    // State register. Streaming comes up enabled with the default destination.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r <= '0;
            s_r.st <= AKFR_RX_HDR;
            s_r.en <= 1'b1;
            s_r.group <= AKFR_DEF_GROUP;
            s_r.port <= AKFR_DEF_PORT;
            s_r.status <= AKFR_STATUS_OK;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Answer bytes queue here so a stalled MAC holds the framer back.
    akfr_fifo #(
        .WIDTH(9),
        .DEPTH(AKFR_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i({(s_r.tx_ofs == AKFR_OFS_LAST), tx_byte}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(tx_ready_i),
        .out_data_o(fifo_out)
    );

    assign tx_valid_o = fifo_out_valid;
    assign tx_data_o = fifo_out[7:0];
    assign tx_last_o = fifo_out_valid && fifo_out[8];
    assign stream_en_o = s_r.en;
    assign stream_group_o = s_r.group;
    assign stream_port_o = s_r.port;
    assign stream_pkt_len_o = s_r.pkt_len;
    assign cmd_ok_o = s_r.ok;
    assign cmd_drop_o = s_r.drop;

    // ==========================================================
    // Checks on the framer's own outputs and on the answer byte generator.
    a_defaults_after_reset: assert property (@(posedge clk_i)
        $fell(srst_i) |-> stream_port_o == 16'h2712 && stream_group_o == 32'hE0000001)
        else $error("Stream destination not at default after reset.");
    a_enable_after_reset: assert property (@(posedge clk_i)
        $fell(srst_i) |-> stream_en_o)
        else $error("Streaming not enabled after reset.");
    a_pkt_len_limit: assert property (@(posedge clk_i) disable iff (srst_i)
        stream_pkt_len_o <= 11'h598)
        else $error("Stream packet longer than allowed.");
    a_data_len_clamp: assert property (@(posedge clk_i) disable iff (srst_i)
        stream_len_i > 11'h578 |=> stream_pkt_len_o == 11'h598)
        else $error("Oversized data section not clamped.");
    a_cfg_write: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_we_i |=> stream_port_o == $past(cfg_port_i))
        else $error("Configured port not taken.");
    a_ok_starts_send: assert property (@(posedge clk_i) disable iff (srst_i)
        cmd_ok_o |-> ##[1:3] tx_valid_o && tx_data_o == 8'hA1)
        else $error("Answer did not start with preamble.");
    a_drop_no_answer: assert property (@(posedge clk_i) disable iff (srst_i)
        cmd_drop_o && !tx_valid_o |=> !tx_valid_o [*2])
        else $error("Rejected command produced an answer.");
    a_cmd_byte: assert property (@(posedge clk_i) disable iff (srst_i)
        fifo_push && fifo_in_ready && s_r.tx_ofs == AKFR_OFS_CMD |-> tx_byte == 8'hFE)
        else $error("Answer command byte wrong.");
    a_rev_byte: assert property (@(posedge clk_i) disable iff (srst_i)
        fifo_push && s_r.tx_ofs == AKFR_OFS_REV |-> tx_byte == 8'h03)
        else $error("Answer version byte wrong.");
    a_zero_len: assert property (@(posedge clk_i) disable iff (srst_i)
        fifo_push && s_r.tx_ofs >= 6'h08 && s_r.tx_ofs <= 6'h0B |-> tx_byte == 8'h00)
        else $error("Answer length not zero.");

    // ==========================================================
    // Checks on the answer as the sink takes it, offset by offset.
    a_out_pre_hi: assert property (
        tx_valid_o && s_r.out_ofs == AKFR_OFS_PRE_HI
        |-> tx_data_o == 8'hA1)
        else $error("Sent preamble high byte wrong.");
    a_out_pre_lo: assert property (
        tx_valid_o && s_r.out_ofs == AKFR_OFS_PRE_LO
        |-> tx_data_o == 8'hEC)
        else $error("Sent preamble low byte wrong.");
    a_out_rev: assert property (
        tx_valid_o && s_r.out_ofs == AKFR_OFS_REV
        |-> tx_data_o == 8'h03)
        else $error("Sent version byte wrong.");
    a_out_cmd: assert property (
        tx_valid_o && s_r.out_ofs == AKFR_OFS_CMD
        |-> tx_data_o == 8'hFE)
        else $error("Sent command byte wrong.");
    a_out_target: assert property (
        tx_valid_o && s_r.out_ofs == AKFR_OFS_TARGET
        |-> tx_data_o == s_r.target)
        else $error("Sent target byte wrong.");
    a_out_status: assert property (
        tx_valid_o && s_r.out_ofs == AKFR_OFS_STATUS
        |-> tx_data_o == s_r.status)
        else $error("Sent status byte wrong.");
    a_out_flags: assert property (
        tx_valid_o && s_r.out_ofs > AKFR_OFS_STATUS && s_r.out_ofs < AKFR_OFS_LEN
        |-> tx_data_o == 8'h00)
        else $error("Sent flags not zero.");
    a_out_len: assert property (
        tx_valid_o && s_r.out_ofs >= AKFR_OFS_LEN && s_r.out_ofs <= AKFR_OFS_LEN_END
        |-> tx_data_o == 8'h00)
        else $error("Sent length not zero.");
    a_out_ignored: assert property (
        tx_valid_o && s_r.out_ofs > AKFR_OFS_LEN_END && s_r.out_ofs < AKFR_OFS_PCK
        |-> tx_data_o == 8'h00)
        else $error("Sent ignored byte not zero.");
    a_out_pck: assert property (
        tx_valid_o && s_r.out_ofs >= AKFR_OFS_PCK && s_r.out_ofs <= AKFR_OFS_PCK_END
        |-> tx_data_o == 8'h00)
        else $error("Sent payload checksum not zero.");
    a_out_crc_hi: assert property (
        tx_valid_o && s_r.out_ofs == AKFR_OFS_HCK_HI
        |-> tx_data_o == s_r.out_crc[15:8])
        else $error("Sent checksum high byte wrong.");
    a_out_crc_lo: assert property (
        tx_valid_o && s_r.out_ofs == AKFR_OFS_LAST
        |-> tx_data_o == s_r.out_crc[7:0])
        else $error("Sent checksum low byte wrong.");
    a_out_last: assert property (
        tx_valid_o
        |-> tx_last_o == (s_r.out_ofs == AKFR_OFS_LAST))
        else $error("Last marker on wrong byte.");
endmodule

// file: logic/akfr_pkg.sv
// Purpose: Constants and types shared by the keep-alive framer and its FIFO.
// Assumes: Byte-wide control link, one byte a cycle, high byte first on the wire.
// Notes: Offsets are byte positions inside the 64-byte control header.
package akfr_pkg;
    // ==========================================================
    // Control header layout
    localparam logic [15:0] AKFR_PREAMBLE = 16'hA1EC;
    localparam logic [7:0] AKFR_PROTO_REV = 8'h03;
    localparam logic [7:0] AKFR_CMD_ALIVE = 8'hFE;
    localparam logic [5:0] AKFR_OFS_PRE_HI = 6'h00;
    localparam logic [5:0] AKFR_OFS_PRE_LO = 6'h01;
    localparam logic [5:0] AKFR_OFS_REV = 6'h02;
    localparam logic [5:0] AKFR_OFS_CMD = 6'h03;
    localparam logic [5:0] AKFR_OFS_TARGET = 6'h04;
    localparam logic [5:0] AKFR_OFS_STATUS = 6'h05;
    localparam logic [5:0] AKFR_OFS_LEN = 6'h08;
    localparam logic [5:0] AKFR_OFS_LEN_END = 6'h0B;
    localparam logic [5:0] AKFR_OFS_PCK = 6'h3A;
    localparam logic [5:0] AKFR_OFS_PCK_END = 6'h3D;
    localparam logic [5:0] AKFR_OFS_HCK_HI = 6'h3E;
    localparam logic [5:0] AKFR_OFS_LAST = 6'h3F;
    localparam logic [15:0] AKFR_CRC_POLY = 16'h1021;
    localparam logic [15:0] AKFR_CRC_INIT = 16'h0000;
    localparam logic [7:0] AKFR_STATUS_OK = 8'h00;
    // ==========================================================
    // Stream shape and default destination
    localparam int AKFR_STREAM_HDR_BYTES = 32;
    localparam int AKFR_STREAM_DATA_MAX = 1400;
    localparam int AKFR_STREAM_PKT_MAX = 1432;
    localparam logic [31:0] AKFR_DEF_GROUP = 32'hE0000001;
    localparam logic [15:0] AKFR_DEF_PORT = 16'h2712;
    localparam int AKFR_FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        AKFR_RX_HDR,
        AKFR_RX_WAIT,
        AKFR_RX_SEND
    } akfr_rx_state_t;

    // One CRC-CCITT step over a byte, most significant bit first.
    function automatic logic [15:0] akfr_crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            if (c[15] ^ b[i]) begin
                c = {c[14:0], 1'b0} ^ AKFR_CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction
endpackage

// file: logic/akfr_fifo.sv
// Purpose: Small flip-flop FIFO with valid and ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Full drops in_ready_o so the producer stalls.
`timescale 1ns/1ps
module akfr_fifo
    import akfr_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = AKFR_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } akfr_fifo_st_t;

    akfr_fifo_st_t s_r;
    akfr_fifo_st_t s_nxt;
    logic push;
    logic pop;

    // ==========================================================
    // Handshake terms come straight from the count.
    assign in_ready_o = (s_r.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (s_r.cnt != '0);
    assign out_data_o = s_r.mem[s_r.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointers wrap at DEPTH so non-power-of-two depths still work.
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data_i;
            s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
        end
        if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// file: dv/akfr_host_model.sv
// Purpose: Behavioural host that feeds control headers in and drains the answer bytes.
// Assumes: One byte a cycle on both sides, inputs changed 1 ns after the rising edge.
// Notes: The receive side can stall to hold the answer FIFO full.
`timescale 1ns/1ps
module akfr_host_model (
    input wire logic clk_i,
    output logic rx_valid_o,
    output logic rx_sof_o,
    output logic [7:0] rx_data_o,
    output logic tx_ready_o,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_last_i
);
    // ==========================================================
    // Idle levels at time zero.
    initial begin
        rx_valid_o = 1'b0;
        rx_sof_o = 1'b0;
        rx_data_o = 8'h00;
        tx_ready_o = 1'b0;
    end

    // ==========================================================
    // Send 64 header bytes back to back, byte 0 first and high byte of each field first.
    task automatic send_hdr(input logic [511:0] fr);
        for (int i = 0; i < 64; i++) begin
            @(posedge clk_i);
            #1;
            rx_valid_o = 1'b1;
            rx_sof_o = (i == 0);
            rx_data_o = fr[511-8*i -: 8];
        end
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b0;
        rx_sof_o = 1'b0;
        // The data line is not held after release, so a stale byte cannot be mistaken.
        rx_data_o = ~rx_data_o;
    endtask

    // ==========================================================
    // Drain one answer; with stall set, ready starts low and drops every third cycle.
    task automatic recv_hdr(input int stall, output logic [511:0] fr, output int n,
                            output int lastn, output int lastat);
        int t;
        t = 0;
        n = 0;
        lastn = 0;
        lastat = -1;
        fr = '0;
        while (n < 64 && t < 2000) begin
            @(posedge clk_i);
            #1;
            tx_ready_o = (stall == 0) || (t >= 10 && t % 3 != 0);
            @(negedge clk_i);
            if (tx_valid_i === 1'b1 && tx_ready_o) begin
                fr[511-8*n -: 8] = tx_data_i;
                if (tx_last_i === 1'b1) begin
                    lastn++;
                    lastat = n;
                end
                n++;
            end
            t++;
        end
        @(posedge clk_i);
        #1;
        tx_ready_o = 1'b0;
    endtask
endmodule

// file: dv/akfr_top_test.sv
// Purpose: Self-checking bench for the keep-alive framer and stream settings.
// Assumes: Host model drives the header stream; bench drives config and answer fields.
// Notes: Expected bytes and CRC are rebuilt here from the header layout.
`timescale 1ns/1ps
module akfr_top_test;
    logic clk_i, srst_i, rx_valid, rx_sof, tx_ready, tx_valid, tx_last, cfg_we, cfg_en;
    logic [7:0] rx_data, tx_data, tgt, res;
    logic [31:0] cfg_group, grp;
    logic [15:0] cfg_port, port;
    logic [10:0] slen, plen;
    logic sen, ok, drop;
    int mismatches = 0, comparisons = 0, ok_cnt = 0, drop_cnt = 0, cycles = 0;

    // ==========================================================
    // Clock, timeout and answer pulse counting.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (ok === 1'b1) ok_cnt++;
        if (drop === 1'b1) drop_cnt++;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end

    akfr_host_model host (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_sof_o(rx_sof),
        .rx_data_o(rx_data), .tx_ready_o(tx_ready), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .tx_last_i(tx_last));
    akfr_top DUT (.clk_i(clk_i), .srst_i(srst_i), .rx_valid_i(rx_valid), .rx_sof_i(rx_sof),
        .rx_data_i(rx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .tx_data_o(tx_data), .tx_last_o(tx_last), .flash_target_i(tgt),
        .result_code_i(res), .cfg_we_i(cfg_we), .cfg_group_i(cfg_group),
        .cfg_port_i(cfg_port), .cfg_enable_i(cfg_en), .stream_len_i(slen),
        .stream_en_o(sen), .stream_group_o(grp), .stream_port_o(port),
        .stream_pkt_len_o(plen), .cmd_ok_o(ok), .cmd_drop_o(drop));

    // ==========================================================
    // Helpers.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // CRC-CCITT over bytes 2..61, MSB first, register starting at zero.
    function automatic logic [15:0] crc_of(input logic [7:0] b [64]);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 2; i < 62; i++) begin
            for (int k = 7; k >= 0; k--) begin
                c = (c[15] ^ b[i][k]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction

    // Build a command; bad selects one corruption, 0 gives a clean one.
    function automatic logic [511:0] make_cmd(input int bad);
        logic [7:0] b [64];
        logic [511:0] f;
        logic [15:0] c;
        // Flags and ignored bytes carry junk that the device must not act on.
        for (int i = 0; i < 64; i++) b[i] = 8'(i * 7 + 1);
        b[0] = 8'hA1;
        b[1] = 8'hEC;
        b[2] = (bad == 2) ? 8'h02 : 8'h03;
        b[3] = (bad == 6) ? 8'hFD : 8'hFE;
        for (int i = 8; i < 12; i++) b[i] = 8'h00;
        for (int i = 58; i < 62; i++) b[i] = 8'h00;
        if (bad == 4) b[11] = 8'h01;
        if (bad == 5) b[61] = 8'h80;
        c = crc_of(b);
        b[62] = c[15:8];
        b[63] = (bad == 3) ? ~c[7:0] : c[7:0];
        if (bad == 1) b[1] = 8'hED;
        for (int i = 0; i < 64; i++) f[511-8*i -: 8] = b[i];
        return f;
    endfunction

    task automatic do_reset();
        @(posedge clk_i);
        #1;
        srst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
    endtask

    // ==========================================================
    // Scenarios.
    task automatic test_defaults();
        check(sen, 1'b1, "stream enable");
        check(grp, 32'hE0000001, "group");
        check(port, 16'd10002, "port");
        check(tx_valid, 1'b0, "tx idle");
        $display("test defaults done");
    endtask

    task automatic test_alive(input logic [7:0] t, input logic [7:0] r, input int stall);
        logic [511:0] f;
        logic [7:0] e [64];
        logic [15:0] c;
        int n, lastn, lastat;
        ok_cnt = 0;
        drop_cnt = 0;
        tgt = t;
        res = r;
        host.send_hdr(make_cmd(0));
        host.recv_hdr(stall, f, n, lastn, lastat);
        for (int i = 0; i < 64; i++) e[i] = 8'h00;
        e[0] = 8'hA1;
        e[1] = 8'hEC;
        e[2] = 8'h03;
        e[3] = 8'hFE;
        e[4] = t;
        e[5] = r;
        // Flags carry no meaning and go out as zero, like the ignored bytes.
        c = crc_of(e);
        e[62] = c[15:8];
        e[63] = c[7:0];
        check(n, 64, "answer length");
        for (int i = 0; i < 64; i++) begin
            check(f[511-8*i -: 8], e[i], "answer byte");
        end
        check(lastn, 1, "last count");
        check(lastat, 63, "last position");
        check(ok_cnt, 1, "ok pulse");
        check(drop_cnt, 0, "no drop");
        $display("test alive done");
    endtask

    task automatic test_bad();
        for (int bad = 1; bad <= 6; bad++) begin
            ok_cnt = 0;
            drop_cnt = 0;
            host.send_hdr(make_cmd(bad));
            repeat (6) @(posedge clk_i);
            #1;
            check(drop_cnt, 1, "drop pulse");
            check(ok_cnt, 0, "no ok");
            check(tx_valid, 1'b0, "no answer");
        end
        $display("test bad done");
    endtask

    task automatic test_cfg();
        cfg_group = 32'hC0A80105;
        cfg_port = 16'd20000;
        cfg_en = 1'b0;
        @(posedge clk_i);
        #1;
        check(grp, 32'hE0000001, "no write without strobe");
        cfg_we = 1'b1;
        @(posedge clk_i);
        #1;
        cfg_we = 1'b0;
        cfg_group = 32'h0;
        @(posedge clk_i);
        #1;
        check(grp, 32'hC0A80105, "new group");
        check(port, 16'd20000, "new port");
        check(sen, 1'b0, "stream off");
        do_reset();
        test_defaults();
        $display("test cfg done");
    endtask

    task automatic test_pkt_len();
        logic [10:0] req [5] = '{11'd0, 11'd100, 11'd1399, 11'd1400, 11'd2047};
        logic [10:0] exp [5] = '{11'd32, 11'd132, 11'd1431, 11'd1432, 11'd1432};
        for (int i = 0; i < 5; i++) begin
            slen = req[i];
            repeat (2) @(posedge clk_i);
            #1;
            check(plen, exp[i], "packet length");
        end
        $display("test pkt len done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        srst_i = 1'b1;
        tgt = 8'h00;
        res = 8'h00;
        cfg_we = 1'b0;
        cfg_group = 32'h0;
        cfg_port = 16'h0;
        cfg_en = 1'b1;
        slen = 11'd0;
        do_reset();
        test_defaults();
        test_alive(8'h02, 8'h00, 0);
        test_alive(8'h5C, 8'hA7, 1);
        test_bad();
        test_alive(8'h01, 8'h3C, 0);
        test_cfg();
        test_pkt_len();
        finish_test();
    end
endmodule
